// [src/sdr_config_regs.sv]
// shadow ram, refresh and dram configuration register bank
`timescale 1ns/10ps
`include "sdr_map.svh"
module sdr_config_regs #(
  parameter int REFRESH_CYCLES = `SDR_REFRESH_CYC // normal refresh interval in clocks
) (
  input wire logic REF_CLK, // system clock, 200 mhz
  input wire logic ARST_N, // async reset, low
  input wire logic [15:0] IO_ADDR, // io port address
  input wire logic IO_WR, // io write strobe, one cycle
  input wire logic IO_RD, // io read strobe, one cycle
  input wire logic [7:0] XD_IN, // peripheral data bus in
  output logic [7:0] XD_OUT, // peripheral data bus out
  output logic XD_OE, // high while driving the data bus
  input wire logic CACHE_EN, // cache enable bit from control register 2
  input wire logic BUS_CLOCK_DIVIDER_STRAP, // strap for divider select bit 0
  input wire logic MEM_REQ, // memory access request, one cycle
  input wire logic MEM_WR, // request is a write
  input wire logic [19:0] MEM_ADDR, // request address
  output logic ROUTE_VALID, // routing answer, one cycle
  output logic SHADOW_HIT, // address lies in c0000h-effffh
  output logic ROUTE_DRAM, // access goes to shadow dram
  output logic ROUTE_BUS, // access goes to rom / expansion bus
  output logic WRITE_DROP, // write is discarded
  output logic REFRESH_REQ, // refresh request, one cycle
  output logic HIDDEN_REFRESH_EN, // refresh without holding cpu
  output logic [2:0] READ_WAIT, // dram read wait states
  output logic [2:0] WRITE_WAIT, // dram write wait states
  output logic FAST_DECODE_ACTIVE, // fast decode in effect
  output sdr_pkg::sdr_dram_kind_t BANK0_KIND, // bank 0 population
  output sdr_pkg::sdr_dram_kind_t BANK1_KIND, // bank 1 population
  output sdr_pkg::sdr_dram_kind_t BANK2_KIND, // bank 2 population
  output sdr_pkg::sdr_dram_kind_t BANK3_KIND, // bank 3 population
  output logic EXPANSION_BUS_CLK_TICK // expansion bus clock enable
);
  import sdr_pkg::*;

  // elaboration check: slow interval must fit the 16-bit counter
  if (REFRESH_CYCLES < 1 || REFRESH_CYCLES * `SDR_SLOW_FACTOR > 65535) begin : g_chk
    $error("REFRESH_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] reg_area; // area control
  logic [7:0] reg_seg; // d/e segment enables
  logic [7:0] reg_bank; // bank types and fast decode
  logic [7:0] reg_wait; // wait states and bus clock
  logic [7:0] reg_carea; // c area control
  sdr_idx_state_t idx_state; // index armed or not
  logic [7:0] idx; // latched index
  logic strap_taken; // strap sampled once after reset
  logic idx_wr; // index port write
  logic data_wr; // armed data write
  logic data_rd; // armed data read
  logic fast_eff; // fast decode after cache gating
  logic [3:0] pair_lo; // bank 0/1 decode
  logic [3:0] pair_hi; // bank 2/3 decode
  logic [7:0] rd_val; // read mux
  logic slow_q; // slow bit, for restart on change
  logic [15:0] ref_cnt; // refresh interval counter
  logic [15:0] ref_limit; // current interval

  // register index owned by this bank
  function automatic logic mine_f(input logic [7:0] i);
    mine_f = (i >= `SDR_IDX_AREA) && (i <= `SDR_IDX_CAREA);
  endfunction : mine_f

  // read wait: base plus field less one, less fast decode
  function automatic logic [2:0] rd_wait_f(input logic [1:0] code, input logic fast);
    logic [2:0] add;
    add = (code == 2'h0) ? 3'h2 : {1'b0, code - 2'h1}; // unused code held at slowest
    rd_wait_f = `SDR_RD_WAIT_BASE + add - {2'h0, fast};
  endfunction : rd_wait_f

  // write wait: base plus upper two field bits, less fast decode
  function automatic logic [2:0] wr_wait_f(input logic [2:0] code, input logic fast);
    logic [2:0] add;
    add = code[0] ? 3'h3 : {1'b0, code[2:1]}; // odd codes unused, held at slowest
    wr_wait_f = `SDR_WR_WAIT_BASE + add - {2'h0, fast};
  endfunction : wr_wait_f

  // bank pair decode from class bit and 3-bit field
  function automatic logic [3:0] bank_f(input logic [3:0] code, input logic upper);
    logic [3:0] pair;
    case (code)
      4'h0: pair = {SDR_KIND_256K, SDR_KIND_NONE};
      4'h1: pair = {SDR_KIND_256K, SDR_KIND_256K};
      4'h2: pair = {SDR_KIND_1M, SDR_KIND_256K};
      4'h8: pair = {SDR_KIND_1M, SDR_KIND_NONE};
      4'h9: pair = {SDR_KIND_1M, SDR_KIND_1M};
      4'ha: pair = {SDR_KIND_1M, SDR_KIND_4M};
      4'hb: pair = {SDR_KIND_4M, SDR_KIND_1M};
      4'hc: pair = {SDR_KIND_4M, SDR_KIND_NONE};
      4'hd: pair = {SDR_KIND_4M, SDR_KIND_4M};
      default: pair = {SDR_KIND_NONE, SDR_KIND_NONE};
    endcase
    // upper banks need the large class and have no 1M/4M pair (code a); the 4M/1M pair is kept
    if (upper && (!code[3] || code == 4'ha)) begin
      pair = {SDR_KIND_NONE, SDR_KIND_NONE};
    end
    bank_f = pair;
  endfunction : bank_f

  ////////////////////////////////////////////////////////////////////////////
  // port decode
  assign idx_wr = IO_WR && (IO_ADDR == `SDR_PORT_INDEX);
  assign data_wr = IO_WR && (IO_ADDR == `SDR_PORT_DATA) && (idx_state == SDR_IDX_ARMED);
  assign data_rd = IO_RD && (IO_ADDR == `SDR_PORT_DATA) && (idx_state == SDR_IDX_ARMED);

  // index state: every data access consumes the index
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      idx_state <= SDR_IDX_IDLE;
      idx <= 8'h00;
    end else begin
      case (idx_state)
        SDR_IDX_IDLE: begin
          if (idx_wr) begin
            idx <= XD_IN;
            idx_state <= SDR_IDX_ARMED;
          end
        end
        SDR_IDX_ARMED: begin
          if (idx_wr) begin
            idx <= XD_IN; // rewrite keeps it armed
          end else if (data_wr || data_rd) begin
            idx_state <= SDR_IDX_IDLE;
          end
        end
        default: idx_state <= SDR_IDX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes; strap is caught on the first edge after release
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      reg_area <= `SDR_RST_AREA;
      reg_seg <= `SDR_RST_SEG;
      reg_bank <= `SDR_RST_BANK;
      reg_wait <= `SDR_RST_WAIT;
      reg_carea <= `SDR_RST_CAREA;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      reg_wait[0] <= BUS_CLOCK_DIVIDER_STRAP;
    end else if (data_wr) begin
      case (idx)
        `SDR_IDX_AREA: reg_area <= XD_IN & `SDR_WMASK_AREA;
        `SDR_IDX_SEG: reg_seg <= XD_IN;
        `SDR_IDX_BANK: reg_bank <= XD_IN;
        `SDR_IDX_WAIT: reg_wait <= XD_IN & `SDR_WMASK_WAIT;
        `SDR_IDX_CAREA: reg_carea <= XD_IN & `SDR_WMASK_CAREA;
        default: ; // index of another block: ignored
      endcase
    end
  end

  // read mux
  always_comb begin
    case (idx)
      `SDR_IDX_AREA: rd_val = reg_area;
      `SDR_IDX_SEG: rd_val = reg_seg;
      `SDR_IDX_BANK: rd_val = reg_bank;
      `SDR_IDX_WAIT: rd_val = reg_wait;
      `SDR_IDX_CAREA: rd_val = reg_carea;
      default: rd_val = 8'h00;
    endcase
  end

  // read answer: drive only for our own indexes, so other banks can share the bus
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      XD_OUT <= 8'h00;
      XD_OE <= 1'b0;
    end else begin
      XD_OE <= data_rd && mine_f(idx);
      XD_OUT <= (data_rd && mine_f(idx)) ? rd_val : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadow routing of one memory request, answered one cycle later
  logic in_c; // request in the c area
  logic in_d; // request in the d area
  logic in_e; // request in the e area
  logic c_on; // c segment shadowed
  logic de_on; // d/e segment shadowed
  logic de_wp; // d/e area write protected
  assign in_c = MEM_ADDR[19:16] == 4'hc;
  assign in_d = MEM_ADDR[19:16] == 4'hd;
  assign in_e = MEM_ADDR[19:16] == 4'he;
  // whole c area enable is active low, then per segment
  assign c_on = !reg_carea[`SDR_B_C_OFF_N] && reg_carea[MEM_ADDR[15:14]];
  // area enable and 16 kb segment enable must both be set
  assign de_on = in_d ? reg_area[`SDR_B_D_EN] && reg_seg[{1'b0, MEM_ADDR[15:14]}]
                      : reg_area[`SDR_B_E_EN] && reg_seg[{1'b1, MEM_ADDR[15:14]}];
  assign de_wp = in_d ? reg_area[`SDR_B_D_WP] : reg_area[`SDR_B_E_WP];
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ROUTE_VALID <= 1'b0;
      SHADOW_HIT <= 1'b0;
      ROUTE_DRAM <= 1'b0;
      ROUTE_BUS <= 1'b0;
      WRITE_DROP <= 1'b0;
    end else begin
      ROUTE_VALID <= MEM_REQ;
      SHADOW_HIT <= MEM_REQ && (in_c || in_d || in_e);
      ROUTE_DRAM <= 1'b0;
      ROUTE_BUS <= 1'b0;
      WRITE_DROP <= 1'b0;
      if (MEM_REQ && in_c) begin
        if (c_on && reg_carea[`SDR_B_COPY] && MEM_WR) begin
          ROUTE_DRAM <= !reg_carea[`SDR_B_C_WP];
          WRITE_DROP <= reg_carea[`SDR_B_C_WP];
        end else begin
          ROUTE_BUS <= 1'b1;
        end
      end else if (MEM_REQ && (in_d || in_e)) begin
        if (!de_on) begin
          ROUTE_BUS <= 1'b1;
        end else if (reg_area[`SDR_B_ROM_EN]) begin
          ROUTE_BUS <= !MEM_WR;
          ROUTE_DRAM <= MEM_WR && !de_wp;
          WRITE_DROP <= MEM_WR && de_wp;
        end else begin
          // ram mode: dram is read and write-protected
          ROUTE_DRAM <= !MEM_WR;
          WRITE_DROP <= MEM_WR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refresh timer; a change of rate restarts the interval
  assign ref_limit = reg_area[`SDR_B_SLOW] ? 16'(REFRESH_CYCLES * `SDR_SLOW_FACTOR)
                                            : 16'(REFRESH_CYCLES);
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ref_cnt <= 16'h0000;
      slow_q <= 1'b0;
      REFRESH_REQ <= 1'b0;
      HIDDEN_REFRESH_EN <= 1'b0;
    end else begin
      slow_q <= reg_area[`SDR_B_SLOW];
      HIDDEN_REFRESH_EN <= !reg_area[`SDR_B_HIDDEN_N];
      if (slow_q != reg_area[`SDR_B_SLOW] || ref_cnt == ref_limit - 16'h0001) begin
        ref_cnt <= 16'h0000;
        REFRESH_REQ <= slow_q == reg_area[`SDR_B_SLOW];
      end else begin
        ref_cnt <= ref_cnt + 16'h0001;
        REFRESH_REQ <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dram timing and bank decode outputs
  assign fast_eff = reg_bank[`SDR_B_FAST] && !CACHE_EN;
  assign pair_lo = bank_f({reg_bank[`SDR_B_CLASS], reg_bank[6:4]}, 1'b0);
  assign pair_hi = bank_f({reg_bank[`SDR_B_CLASS], reg_bank[2:0]}, 1'b1);
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      READ_WAIT <= 3'h0;
      WRITE_WAIT <= 3'h0;
      FAST_DECODE_ACTIVE <= 1'b0;
      BANK0_KIND <= SDR_KIND_NONE;
      BANK1_KIND <= SDR_KIND_NONE;
      BANK2_KIND <= SDR_KIND_NONE;
      BANK3_KIND <= SDR_KIND_NONE;
    end else begin
      READ_WAIT <= rd_wait_f(reg_wait[7:6], fast_eff);
      WRITE_WAIT <= wr_wait_f(reg_wait[5:3], fast_eff);
      FAST_DECODE_ACTIVE <= fast_eff;
      BANK0_KIND <= sdr_dram_kind_t'(pair_lo[3:2]);
      BANK1_KIND <= sdr_dram_kind_t'(pair_lo[1:0]);
      BANK2_KIND <= sdr_dram_kind_t'(pair_hi[3:2]);
      BANK3_KIND <= sdr_dram_kind_t'(pair_hi[1:0]);
    end
  end

  // expansion bus clock enable from the select field
  sdr_bus_clk_div u_div (
    .clk(REF_CLK),
    .rst_n(ARST_N),
    .sel(reg_wait[1:0]),
    .tick(EXPANSION_BUS_CLK_TICK)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  // helper: cycles since last refresh pulse or rate change
  logic [15:0] gap;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gap <= 16'h0000;
    end else if (slow_q != reg_area[`SDR_B_SLOW]) begin
      gap <= 16'h0000; // a restart clears the counter, one step behind a pulse
    end else if (REFRESH_REQ) begin
      gap <= 16'h0001;
    end else begin
      gap <= gap + 16'h0001;
    end
  end

  sequence s_index(logic [7:0] v);
    idx_wr && XD_IN == v;
  endsequence
  sequence s_data_wr(logic [7:0] v);
    IO_WR && IO_ADDR == `SDR_PORT_DATA && XD_IN == v;
  endsequence

  AST_ROM_READ: assert property (MEM_REQ && !MEM_WR && MEM_ADDR[19:16] == 4'hd
    && reg_area[`SDR_B_ROM_EN] |=> ROUTE_BUS && !ROUTE_DRAM)
    else $error("rom mode read not routed to rom");
  AST_RAM_WRITE_DROP: assert property (MEM_REQ && MEM_WR && MEM_ADDR[19:16] == 4'he
    && reg_area[`SDR_B_E_EN] && reg_seg[{1'b1, MEM_ADDR[15:14]}]
    && !reg_area[`SDR_B_ROM_EN] |=> WRITE_DROP && !ROUTE_DRAM)
    else $error("ram mode write reached dram");
  AST_D_OFF: assert property (MEM_REQ && MEM_ADDR[19:16] == 4'hd
    && !reg_area[`SDR_B_D_EN] |=> !ROUTE_DRAM && SHADOW_HIT)
    else $error("disabled d area routed to dram");
  AST_D_WP: assert property (MEM_REQ && MEM_WR && MEM_ADDR[19:16] == 4'hd
    && reg_area[`SDR_B_D_WP] |=> !ROUTE_DRAM)
    else $error("protected d write reached dram");
  AST_HIDDEN: assert property (reg_area[`SDR_B_HIDDEN_N] [*2] |-> !HIDDEN_REFRESH_EN)
    else $error("hidden refresh on while disabled");
  AST_REFRESH_GAP: assert property (REFRESH_REQ |-> gap == ref_limit)
    else $error("refresh interval wrong");
  AST_BANK_DECODE: assert property (s_index(`SDR_IDX_BANK) ##[1:2] s_data_wr(8'h91)
    |-> ##2 BANK0_KIND == SDR_KIND_1M && BANK1_KIND == SDR_KIND_1M
    && BANK2_KIND == SDR_KIND_1M && BANK3_KIND == SDR_KIND_1M)
    else $error("bank decode wrong");
  AST_CACHE_NO_FAST: assert property (CACHE_EN |=> !FAST_DECODE_ACTIVE)
    else $error("fast decode active with cache on");
  AST_READ_WAIT: assert property ((reg_wait[7:6] == 2'h1 && !fast_eff) [*2]
    |-> READ_WAIT == 3'h3)
    else $error("read wait wrong");
  AST_C_NO_COPY: assert property (MEM_REQ && MEM_ADDR[19:16] == 4'hc
    && !reg_carea[`SDR_B_COPY] |=> ROUTE_BUS && !ROUTE_DRAM)
    else $error("c area without copy left the bus");
  AST_STRAP: assert property ($rose(strap_taken)
    |-> reg_wait[0] == $past(BUS_CLOCK_DIVIDER_STRAP))
    else $error("strap not loaded");
  AST_INDEX_USED: assert property (data_wr || data_rd |=> idx_state == SDR_IDX_IDLE)
    else $error("index survived a data access");
endmodule : sdr_config_regs

// [common/sdr_map.svh]
// register map, field positions, reset values and timing counts of the shadow/dram config bank
// Functional notes
// - rom routing bit steers d/e area shadow reads and writes
// - d and e area shadow enables, reset off
// - d and e area write protects, reset off
// - hidden refresh enable is active low, reset off
// - slow refresh runs at quarter rate
// - eight 16 kb d/e segment enables
// - decode bank 0 and 1 population
// - decode bank 2 and 3 population
// - fast decode removes one wait state
// - cache enable forces fast decode off
// - read wait is two plus field, field zero held at slowest
// - write wait is two plus the upper two field bits, odd codes held at slowest
// - expansion bus clock divider select
// - strap pin loads divider select bit zero
// - copy enable steers c area traffic
// - c area write protect bit
// - c area whole shadow enable, active low
// - four 16 kb c segment enables
// - index port then data port, index consumed
`ifndef SDR_MAP_SVH
`define SDR_MAP_SVH
// io ports of the index/data pair
`define SDR_PORT_INDEX 16'h0022
`define SDR_PORT_DATA 16'h0024
// register indexes
`define SDR_IDX_AREA 8'h22
`define SDR_IDX_SEG 8'h23
`define SDR_IDX_BANK 8'h24
`define SDR_IDX_WAIT 8'h25
`define SDR_IDX_CAREA 8'h26
// reset values (bit 0 of the wait register is replaced by the strap)
`define SDR_RST_AREA 8'h84
`define SDR_RST_SEG 8'h00
`define SDR_RST_BANK 8'h87
`define SDR_RST_WAIT 8'hf0
`define SDR_RST_CAREA 8'h00
// writable bits; unused bits stay zero
`define SDR_WMASK_AREA 8'hfd
`define SDR_WMASK_WAIT 8'hfb
`define SDR_WMASK_CAREA 8'h7f
// field positions
`define SDR_B_ROM_EN 7
`define SDR_B_D_EN 6
`define SDR_B_E_EN 5
`define SDR_B_D_WP 4
`define SDR_B_E_WP 3
`define SDR_B_HIDDEN_N 2
`define SDR_B_SLOW 0
`define SDR_B_CLASS 7
`define SDR_B_FAST 3
`define SDR_B_COPY 6
`define SDR_B_C_WP 5
`define SDR_B_C_OFF_N 4
// wait state bases
`define SDR_RD_WAIT_BASE 3'h3
`define SDR_WR_WAIT_BASE 3'h2
// expansion bus clock divisors
`define SDR_DIV_SEL0 3'h6
`define SDR_DIV_SEL1 3'h4
`define SDR_DIV_SEL2 3'h3
`define SDR_DIV_SEL3 3'h5
// refresh interval
`define SDR_REFRESH_NS 15600
`define SDR_CLK_NS 5
`define SDR_REFRESH_CYC (`SDR_REFRESH_NS / `SDR_CLK_NS)
`define SDR_SLOW_FACTOR 4
`endif

// [common/sdr_pkg.sv]
// shared types of the shadow/dram config bank
package sdr_pkg;
  // population of one dram bank
  typedef enum logic [1:0] {SDR_KIND_NONE, SDR_KIND_256K, SDR_KIND_1M, SDR_KIND_4M} sdr_dram_kind_t;
  // index port state
  typedef enum logic {SDR_IDX_IDLE, SDR_IDX_ARMED} sdr_idx_state_t;
endpackage : sdr_pkg

// [src/sdr_bus_clk_div.sv]
// expansion bus clock enable divider
`timescale 1ns/10ps
`include "sdr_map.svh"
module sdr_bus_clk_div (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, low
  input wire logic [1:0] sel, // divider select field
  output logic tick // one-cycle enable at divided rate
);
  logic [2:0] cnt; // cycle counter within period
  logic [1:0] sel_q; // last select, to restart on change

  // divisor per select code
  function automatic logic [2:0] div_f(input logic [1:0] s);
    case (s)
      2'h0: div_f = `SDR_DIV_SEL0;
      2'h1: div_f = `SDR_DIV_SEL1;
      2'h2: div_f = `SDR_DIV_SEL2;
      default: div_f = `SDR_DIV_SEL3;
    endcase
  endfunction : div_f

  ////////////////////////////////////////////////////////////////////////////
  // counter restarts on a new select so no short period slips out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 3'h0;
      sel_q <= 2'h0;
      tick <= 1'b0;
    end else begin
      sel_q <= sel;
      if (sel != sel_q) begin
        cnt <= 3'h0;
        tick <= 1'b0;
      end else if (cnt == div_f(sel) - 3'h1) begin
        cnt <= 3'h0;
        tick <= 1'b1;
      end else begin
        cnt <= cnt + 3'h1;
        tick <= 1'b0;
      end
    end
  end
endmodule : sdr_bus_clk_div

// [verification/tb_top.sv]
// self-checking testbench of the shadow/dram configuration register bank
`timescale 1ns/10ps
`include "sdr_map.svh"
module tb_top;
  import sdr_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  logic ref_clk, arst_n, io_wr, io_rd, cache_en, strap, mem_req, mem_wr; // bench-driven inputs
  logic [15:0] io_addr; // io port address
  logic [7:0] xd_in, xd_out; // data bus both ways
  logic [19:0] mem_addr; // routing request address
  logic xd_oe, route_valid, shadow_hit, route_dram, route_bus, write_drop; // design answers
  logic refresh_req, hidden_refresh_en, fast_decode_active, bus_tick; // derived levels and pulses
  logic [2:0] read_wait, write_wait; // wait state counts
  sdr_dram_kind_t bank0_kind, bank1_kind, bank2_kind, bank3_kind; // bank population
  int miscompares = 0; // mismatches seen
  int checks_done = 0; // comparisons made
  int cycles = 0; // timeout counter
  // bank register values and the packed kinds {b0,b1,b2,b3} the decode tables give
  logic [7:0] bank_v [14] = '{8'h87, 8'h00, 8'h10, 8'h20, 8'h30, 8'h98, 8'ha1, 8'hb3, 8'hc4,
    8'hd5, 8'he2, 8'hf6, 8'h45, 8'h91};
  logic [7:0] bank_e [14] = '{8'h80, 8'h40, 8'h50, 8'h90, 8'h00, 8'ha8, 8'hba, 8'hee, 8'hcc,
    8'hff, 8'h00, 8'h00, 8'h00, 8'haa};
  // small refresh interval keeps the run short; expectations use the same value
  sdr_config_regs #(.REFRESH_CYCLES(8)) dut (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd), .XD_IN(xd_in), .XD_OUT(xd_out),
    .XD_OE(xd_oe), .CACHE_EN(cache_en), .BUS_CLOCK_DIVIDER_STRAP(strap), .MEM_REQ(mem_req),
    .MEM_WR(mem_wr), .MEM_ADDR(mem_addr), .ROUTE_VALID(route_valid), .SHADOW_HIT(shadow_hit),
    .ROUTE_DRAM(route_dram), .ROUTE_BUS(route_bus), .WRITE_DROP(write_drop),
    .REFRESH_REQ(refresh_req), .HIDDEN_REFRESH_EN(hidden_refresh_en), .READ_WAIT(read_wait),
    .WRITE_WAIT(write_wait), .FAST_DECODE_ACTIVE(fast_decode_active), .BANK0_KIND(bank0_kind),
    .BANK1_KIND(bank1_kind), .BANK2_KIND(bank2_kind), .BANK3_KIND(bank3_kind),
    .EXPANSION_BUS_CLK_TICK(bus_tick));
  //////////////////////////////////////////////////////////////////////////////
  // 200 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // hang guard: the whole sequence needs a few thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // the one compare of the bench, four-state exact
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one io write cycle, strobe high for one clock
  task automatic io_w(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io_addr = a;
    xd_in = d;
    io_wr = 1'b1;
    @(negedge ref_clk);
    io_wr = 1'b0;
  endtask : io_w
  // index then data write; waits until derived outputs have followed
  task automatic reg_w(input logic [7:0] idx, input logic [7:0] d);
    io_w(`SDR_PORT_INDEX, idx);
    io_w(`SDR_PORT_DATA, d);
    repeat (2) @(negedge ref_clk);
  endtask : reg_w
  // optional index write, then a data read; drive flag and data checked one edge later
  task automatic reg_r(input logic arm, input logic [7:0] idx, input logic oe,
    input logic [7:0] exp);
    if (arm) io_w(`SDR_PORT_INDEX, idx);
    @(negedge ref_clk);
    io_addr = `SDR_PORT_DATA;
    io_rd = 1'b1;
    @(negedge ref_clk);
    io_rd = 1'b0;
    chk({7'h0, xd_oe}, {7'h0, oe}, "read drive");
    chk(xd_out, exp, "read data");
  endtask : reg_r
  // one routing request; expects {hit, dram, bus, drop} with the valid pulse
  task automatic route(input logic [19:0] a, input logic w, input logic [3:0] e);
    @(negedge ref_clk);
    mem_addr = a;
    mem_wr = w;
    mem_req = 1'b1;
    @(negedge ref_clk);
    mem_req = 1'b0;
    chk({3'h0, route_valid, shadow_hit, route_dram, route_bus, write_drop}, {4'h1, e}, "route");
  endtask : route
  // distance in cycles between two pulses of the divider tick or the refresh request
  task automatic period(input logic sel, input int exp);
    int n;
    n = 0;
    while ((sel ? refresh_req : bus_tick) !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    n = 1;
    while ((sel ? refresh_req : bus_tick) !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n[7:0], exp[7:0], "pulse period");
  endtask : period
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] ra, wa, fe;
    {io_wr, io_rd, mem_req, mem_wr, cache_en} = 5'h00;
    strap = 1'b1;
    io_addr = 16'h0000;
    xd_in = 8'h00;
    mem_addr = 20'h00000;
    arst_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    // reset values, strap in the divider select
    reg_r(1'b1, `SDR_IDX_AREA, 1'b1, 8'h84);
    reg_r(1'b1, `SDR_IDX_SEG, 1'b1, 8'h00);
    reg_r(1'b1, `SDR_IDX_BANK, 1'b1, 8'h87);
    reg_r(1'b1, `SDR_IDX_WAIT, 1'b1, 8'hf1);
    reg_r(1'b1, `SDR_IDX_CAREA, 1'b1, 8'h00);
    chk({7'h0, hidden_refresh_en}, 8'h00, "hidden after reset");
    period(1'b0, 4);
    period(1'b1, 8);
    $display("reset test done");
    // index consumed by each data access, unmapped index, unused bits
    reg_w(`SDR_IDX_SEG, 8'h5a);
    io_w(`SDR_PORT_DATA, 8'hff);
    reg_r(1'b1, `SDR_IDX_SEG, 1'b1, 8'h5a);
    reg_r(1'b0, 8'h00, 1'b0, 8'h00);
    reg_w(8'h27, 8'hff);
    reg_r(1'b1, 8'h27, 1'b0, 8'h00);
    reg_w(`SDR_IDX_AREA, 8'hff);
    reg_w(`SDR_IDX_WAIT, 8'hff);
    reg_w(`SDR_IDX_CAREA, 8'hff);
    reg_r(1'b1, `SDR_IDX_AREA, 1'b1, 8'hfd);
    reg_r(1'b1, `SDR_IDX_WAIT, 1'b1, 8'hfb);
    reg_r(1'b1, `SDR_IDX_CAREA, 1'b1, 8'h7f);
    $display("access test done");
    // hidden and slow refresh
    reg_w(`SDR_IDX_AREA, 8'h80);
    chk({7'h0, hidden_refresh_en}, 8'h01, "hidden on");
    period(1'b1, 8);
    reg_w(`SDR_IDX_AREA, 8'h81);
    period(1'b1, 32);
    $display("refresh test done");
    // bank population decode over both tables
    for (int i = 0; i < 14; i++) begin
      reg_w(`SDR_IDX_BANK, bank_v[i]);
      chk({bank0_kind, bank1_kind, bank2_kind, bank3_kind}, bank_e[i], "banks");
    end
    $display("bank test done");
    // wait states over every code, fast decode with and without cache
    for (int k = 0; k < 128; k++) begin
      @(negedge ref_clk);
      cache_en = k[6];
      reg_w(`SDR_IDX_BANK, {4'h8, k[5], 3'h0});
      reg_w(`SDR_IDX_WAIT, {k[4:0], 3'h0});
      ra = (k[4:3] == 2'h1) ? 8'h0 : ((k[4:3] == 2'h2) ? 8'h1 : 8'h2);
      wa = k[0] ? 8'h3 : {6'h0, k[2:1]};
      fe = {7'h0, k[5] & ~k[6]};
      chk({7'h0, fast_decode_active}, fe, "fast decode");
      chk({5'h0, read_wait}, 8'h3 + ra - fe, "read wait");
      chk({5'h0, write_wait}, 8'h2 + wa - fe, "write wait");
    end
    cache_en = 1'b0;
    $display("wait test done");
    // expansion bus clock divisor per select code
    for (int s = 0; s < 4; s++) begin
      reg_w(`SDR_IDX_WAIT, {6'h3c, s[1:0]});
      period(1'b0, (s == 0) ? 6 : ((s == 1) ? 4 : ((s == 2) ? 3 : 5)));
    end
    $display("divider test done");
    // routing of c area
    route(20'ha0000, 1'b0, 4'h0);
    route(20'hc0000, 1'b0, 4'ha);
    reg_w(`SDR_IDX_CAREA, 8'h41);
    route(20'hc0000, 1'b1, 4'hc);
    route(20'hc0000, 1'b0, 4'ha);
    route(20'hc4000, 1'b1, 4'ha);
    reg_w(`SDR_IDX_CAREA, 8'h6f);
    route(20'hcc000, 1'b1, 4'h9);
    reg_w(`SDR_IDX_CAREA, 8'h5f);
    route(20'hc8000, 1'b1, 4'ha);
    reg_w(`SDR_IDX_CAREA, 8'h0f);
    route(20'hc0000, 1'b1, 4'ha);
    // routing of d and e areas in rom and ram modes
    reg_w(`SDR_IDX_SEG, 8'h81);
    reg_w(`SDR_IDX_AREA, 8'hc0);
    route(20'hd0000, 1'b1, 4'hc);
    route(20'hd0000, 1'b0, 4'ha);
    route(20'hec000, 1'b1, 4'ha);
    reg_w(`SDR_IDX_AREA, 8'hd0);
    route(20'hd0000, 1'b1, 4'h9);
    reg_w(`SDR_IDX_AREA, 8'ha8);
    route(20'hec000, 1'b1, 4'h9);
    reg_w(`SDR_IDX_AREA, 8'h20);
    route(20'hec000, 1'b0, 4'hc);
    route(20'hec000, 1'b1, 4'h9);
    route(20'he0000, 1'b0, 4'ha);
    route(20'hd4000, 1'b0, 4'ha);
    $display("routing test done");
    final_report();
  end
endmodule : tb_top
